// *** common/standby_cfg.svh ***
// Offsets, field positions, reset values and cycle counts for the standby pad pair.
// Assumes a single clock that is also the device's input master clock.
`ifndef STANDBY_CFG_SVH
`define STANDBY_CFG_SVH
// Device register offsets
`define OFF_SYS_CTRL 16'h0018
`define OFF_RESET_CTRL 16'h001a
`define OFF_POWERUP_GPIO 16'h0024
`define OFF_PAD_CTRL 16'h0030
`define OFF_ID_MEM 16'h0040
`define OFF_GPIO_DATA 16'h1070
`define OFF_GPIO_SET 16'h1074
`define OFF_GPIO_CLR 16'h1076
`define OFF_GPIO_DIR 16'h1078
// Field positions
`define BIT_STBY_REQ 0
`define BIT_STBY_EN 3
`define BIT_STBY_STAT 14
`define BIT_OE_PIN_EN 8
`define GPIO_LSB 9
`define PAD_PAR_EN 0
`define PAD_FORCE_HIZ 1
`define PAD_STBY_DRIVE 2
`define PAD_RAW10 3
`define PAD_FLASH_EN 4
`define PAD_FLASH_SEL 5
// Reset values
`define GPIO_DIR_RST 4'hf
`define PAD_CTRL_RST 6'h01
// Timing in input master clock cycles
`define ENTRY_TAIL_CYC 40
`define CLK_AFTER_STBY_CYC 10
`define CLK_BEFORE_EXIT_CYC 10
`define MIN_STBY_CYC 120
`define SYNC_SETTLE_CYC 4
// Host register byte offsets on the Avalon side, and the error-clear bit of the host control register
`define HOFF_ADDR 5'h00
`define HOFF_WDATA 5'h04
`define HOFF_CTRL 5'h08
`define HOFF_RDATA 5'h0c
`define HOFF_PINS 5'h10
`define HOFF_STAT 5'h14
`define HCTRL_ERR_CLR 8
`endif

// *** common/standby_link_if.sv ***
// Register port and pads between host and device.
// Assumes one clock; the shared GPIO wire is resolved here with a pull-up.
`default_nettype none
interface standby_link_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	logic [3:0] dev_gpio_o;
	logic [3:0] dev_gpio_oe_n;
	logic [3:0] host_gpio_o;
	logic [3:0] host_gpio_oe_n;
	logic [3:0] gpio_lvl;
	logic [7:0] pix_data;
	logic pix_clk;
	logic line_valid;
	logic frame_valid;
	logic pix_oe_n;
	logic [3:0] diff;
	// Device wins a clash; undriven pins float high
	assign gpio_lvl = (~dev_gpio_oe_n & dev_gpio_o) | (dev_gpio_oe_n & ~host_gpio_oe_n & host_gpio_o)
		| (dev_gpio_oe_n & host_gpio_oe_n);
	modport device (
		input req, we, addr, wdata, gpio_lvl,
		output ack, rdata, dev_gpio_o, dev_gpio_oe_n, pix_data, pix_clk, line_valid, frame_valid, pix_oe_n, diff
	);
	modport host (
		output req, we, addr, wdata, host_gpio_o, host_gpio_oe_n,
		input ack, rdata, gpio_lvl, pix_data, pix_clk, line_valid, frame_valid, pix_oe_n, diff
	);
endinterface : standby_link_if
`default_nettype wire

// *** common/standby_pkg.sv ***
// Types shared by the standby pad device and its host.
// Assumes standby_cfg.svh supplies all numeric constants.
`default_nettype none
package standby_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_WAIT_FRAME = 3'b001,
		ST_TAIL = 3'b010,
		ST_STANDBY = 3'b011,
		ST_EXIT = 3'b100
	} stby_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_ISSUE = 2'b01,
		H_WAIT = 2'b10
	} host_state_t;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_WRITE = 3'b001,
		OP_READ = 3'b010,
		OP_ENTER = 3'b011,
		OP_EXIT = 3'b100
	} host_op_t;
endpackage : standby_pkg
`default_nettype wire

// *** hdl/standby_pad_device.sv ***
// Device end: soft standby sequencing, pad states, GPIO functions and id memory.
// Assumes clk_i is the input master clock and the host keeps the register port protocol.
//
// Added by the designer: the register port toward the host and the address map.
`include "standby_cfg.svh"
`default_nettype none
module standby_pad_device #(
	parameter int ENTRY_TAIL = `ENTRY_TAIL_CYC,
	parameter int MIN_STBY = `MIN_STBY_CYC,
	parameter int EXIT_WAIT = `CLK_BEFORE_EXIT_CYC,
	parameter logic [7:0] ID_BYTE0 = 8'h3c, // Arbitrary value
	parameter logic [7:0] ID_BYTE1 = 8'hc3 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Pins toward the host
	standby_link_if.device lnk,
	// Pixel pipeline
	input wire logic [9:0] pix_data_i,
	input wire logic pix_clk_i,
	input wire logic line_valid_i,
	input wire logic frame_valid_i,
	input wire logic frame_end_i,
	// Flash and shutter
	input wire logic flash_i,
	input wire logic shutter_i,
	// Status
	output logic standby_o,
	output logic [3:0] powerup_id_o
);
	if (ENTRY_TAIL < 1 || ENTRY_TAIL > 255 || MIN_STBY < 1 || MIN_STBY > 255 || EXIT_WAIT < 1 || EXIT_WAIT > 255) begin
		$error("standby_pad_device: cycle counts must lie in 1..255");
	end

	standby_pkg::stby_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic req_r, en_r, oe_pin_en_r;
	logic [5:0] pad_ctrl_r;
	logic [3:0] gpio_val_r, gpio_dir_r, powerup_r;
	logic [2:0] settle_r;
	logic sampled_r;
	logic ack_r;
	logic [15:0] rdata_r;
	logic [3:0] s1_r, s2_r, s3_r, gpio_in_r;
	logic [7:0] pix_data_r;
	logic pix_clk_r, line_valid_r, frame_valid_r, pix_oe_n_r;
	logic [3:0] gpio_o_r, gpio_oe_n_r, diff_r;

	// Three-stage pin synchronisers; a level counts once stages two and three agree
	for (genvar g = 0; g < 4; g++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				s1_r[g] <= 1'b0;
				s2_r[g] <= 1'b0;
				s3_r[g] <= 1'b0;
				gpio_in_r[g] <= 1'b0;
			end else begin
				s1_r[g] <= lnk.gpio_lvl[g];
				s2_r[g] <= s1_r[g];
				s3_r[g] <= s2_r[g];
				if (s2_r[g] == s3_r[g]) begin
					gpio_in_r[g] <= s3_r[g];
				end
			end
		end
	end

	// Register port decode
	wire wr = lnk.req & lnk.we;
	wire wr_sys = wr & (lnk.addr == `OFF_SYS_CTRL);
	wire wr_rst = wr & (lnk.addr == `OFF_RESET_CTRL);
	wire wr_pad = wr & (lnk.addr == `OFF_PAD_CTRL);
	wire wr_set = wr & (lnk.addr == `OFF_GPIO_SET);
	wire wr_clr = wr & (lnk.addr == `OFF_GPIO_CLR);
	wire wr_dir = wr & (lnk.addr == `OFF_GPIO_DIR);
	wire [3:0] wfield = lnk.wdata[`GPIO_LSB+3:`GPIO_LSB];

	// Pads keep their standby state until status drops, so the exit wait still counts as standby
	wire stby_act = (state_r == standby_pkg::ST_STANDBY) | (state_r == standby_pkg::ST_EXIT);
	// Status follows the sequencer, never the request bit
	wire stby_stat = stby_act;

	wire [15:0] rd_sys = {1'b0, stby_stat, 10'h000, en_r, 2'b00, req_r};
	wire [15:0] rd_rst = {7'h00, oe_pin_en_r, 8'h00};
	wire [15:0] rd_pwr = {12'h000, powerup_r};
	wire [15:0] rd_pad = {10'h000, pad_ctrl_r};
	wire [15:0] rd_id = {ID_BYTE1, ID_BYTE0};
	wire [15:0] rd_in = {3'h0, gpio_in_r, 9'h000};
	wire [15:0] rd_out = {3'h0, gpio_val_r, 9'h000};
	wire [15:0] rd_dir = {3'h0, gpio_dir_r, 9'h000};
	wire [15:0] rd_mux = (lnk.addr == `OFF_SYS_CTRL) ? rd_sys :
		(lnk.addr == `OFF_RESET_CTRL) ? rd_rst :
		(lnk.addr == `OFF_POWERUP_GPIO) ? rd_pwr :
		(lnk.addr == `OFF_PAD_CTRL) ? rd_pad :
		(lnk.addr == `OFF_ID_MEM) ? rd_id :
		(lnk.addr == `OFF_GPIO_DATA) ? rd_in :
		(lnk.addr == `OFF_GPIO_SET) ? rd_out :
		(lnk.addr == `OFF_GPIO_CLR) ? rd_out :
		(lnk.addr == `OFF_GPIO_DIR) ? rd_dir : 16'h0000;

	// Standby sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			standby_pkg::ST_RUN: begin
				if (en_r && req_r) begin
					state_nxt = standby_pkg::ST_WAIT_FRAME;
				end
			end
			standby_pkg::ST_WAIT_FRAME: begin
				if (!req_r) begin
					state_nxt = standby_pkg::ST_RUN;
				end else if (frame_end_i) begin
					state_nxt = standby_pkg::ST_TAIL;
					cnt_nxt = 8'h00;
				end
			end
			standby_pkg::ST_TAIL: begin
				if (cnt_r == 8'(ENTRY_TAIL - 1)) begin
					state_nxt = standby_pkg::ST_STANDBY;
					cnt_nxt = 8'h00;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			standby_pkg::ST_STANDBY: begin
				// Minimum stay in standby before an exit is honoured
				if (cnt_r != 8'(MIN_STBY)) begin
					cnt_nxt = cnt_r + 8'h01;
				end else if (!req_r) begin
					state_nxt = standby_pkg::ST_EXIT;
					cnt_nxt = 8'h00;
				end
			end
			standby_pkg::ST_EXIT: begin
				if (cnt_r == 8'(EXIT_WAIT - 1)) begin
					state_nxt = standby_pkg::ST_RUN;
					cnt_nxt = 8'h00;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			default: begin
				state_nxt = standby_pkg::ST_RUN;
				cnt_nxt = 8'h00;
			end
		endcase
	end

	// Pixel pad enable: register control, gated by the low-active GPIO3 pin when enabled; in standby either one drives
	wire oe_pin_low = oe_pin_en_r & ~gpio_in_r[3];
	wire pix_drive = stby_act ? (pad_ctrl_r[`PAD_STBY_DRIVE] | oe_pin_low) :
		(pad_ctrl_r[`PAD_PAR_EN] & ~pad_ctrl_r[`PAD_FORCE_HIZ] & (~oe_pin_en_r | oe_pin_low));

	// GPIO function overlay
	wire raw10 = pad_ctrl_r[`PAD_RAW10];
	wire flash_en = pad_ctrl_r[`PAD_FLASH_EN];
	wire flash_val = pad_ctrl_r[`PAD_FLASH_SEL] ? shutter_i : flash_i;
	wire [3:0] gpio_val_nxt = {gpio_val_r[3], flash_en ? flash_val : gpio_val_r[2],
		raw10 ? pix_data_i[1:0] : gpio_val_r[1:0]};
	wire [3:0] gpio_drv = {~gpio_dir_r[3] & ~oe_pin_en_r, flash_en | ~gpio_dir_r[2],
		{2{raw10}} | ~gpio_dir_r[1:0]};

	// Core is stopped in standby, so the serial lines carry nothing
	wire [3:0] diff_nxt = stby_act ? 4'h0 : {pix_clk_i, ~pix_clk_i, pix_data_i[2], ~pix_data_i[2]};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= standby_pkg::ST_RUN;
			cnt_r <= 8'h00;
			req_r <= 1'b0;
			en_r <= 1'b0;
			oe_pin_en_r <= 1'b0;
			pad_ctrl_r <= `PAD_CTRL_RST;
			gpio_val_r <= 4'h0;
			gpio_dir_r <= `GPIO_DIR_RST;
			ack_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ack_r <= lnk.req;
			rdata_r <= lnk.req ? rd_mux : 16'h0000;
			if (wr_sys) begin
				req_r <= lnk.wdata[`BIT_STBY_REQ];
				en_r <= lnk.wdata[`BIT_STBY_EN];
			end
			if (wr_rst) begin
				oe_pin_en_r <= lnk.wdata[`BIT_OE_PIN_EN];
			end
			if (wr_pad) begin
				pad_ctrl_r <= lnk.wdata[5:0];
			end
			if (wr_dir) begin
				gpio_dir_r <= wfield;
			end
			gpio_val_r <= wr_set ? (gpio_val_r | wfield) : wr_clr ? (gpio_val_r & ~wfield) : gpio_val_r;
		end
	end

	// Power-up capture once the synchronisers have settled
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			settle_r <= 3'h0;
			sampled_r <= 1'b0;
			powerup_r <= 4'h0;
		end else if (!sampled_r) begin
			settle_r <= settle_r + 3'h1;
			if (settle_r == 3'(`SYNC_SETTLE_CYC)) begin
				sampled_r <= 1'b1;
				powerup_r <= gpio_in_r;
			end
		end
	end

	// Pads: floating and differential low during reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pix_oe_n_r <= 1'b1;
			pix_data_r <= 8'h00;
			pix_clk_r <= 1'b0;
			line_valid_r <= 1'b0;
			frame_valid_r <= 1'b0;
			gpio_o_r <= 4'h0;
			gpio_oe_n_r <= 4'hf;
			diff_r <= 4'h0;
			standby_o <= 1'b0;
			powerup_id_o <= 4'h0;
		end else begin
			pix_oe_n_r <= ~pix_drive;
			pix_data_r <= stby_act ? 8'h00 : pix_data_i[9:2];
			pix_clk_r <= stby_act ? 1'b0 : pix_clk_i;
			line_valid_r <= stby_act ? 1'b0 : line_valid_i;
			frame_valid_r <= stby_act ? 1'b0 : frame_valid_i;
			gpio_o_r <= gpio_val_nxt;
			gpio_oe_n_r <= ~gpio_drv;
			diff_r <= diff_nxt;
			standby_o <= stby_stat;
			powerup_id_o <= powerup_r;
		end
	end

	assign lnk.ack = ack_r;
	assign lnk.rdata = rdata_r;
	assign lnk.pix_data = pix_data_r;
	assign lnk.pix_clk = pix_clk_r;
	assign lnk.line_valid = line_valid_r;
	assign lnk.frame_valid = frame_valid_r;
	assign lnk.pix_oe_n = pix_oe_n_r;
	assign lnk.dev_gpio_o = gpio_o_r;
	assign lnk.dev_gpio_oe_n = gpio_oe_n_r;
	assign lnk.diff = diff_r;
endmodule : standby_pad_device
`default_nettype wire

// *** hdl/standby_pad_host.sv ***
// Host end: Avalon-MM slave that turns software orders into register port cycles.
// Assumes the device answers each request with one ack; clock never stops here.
`include "standby_cfg.svh"
`default_nettype none
module standby_pad_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Device pins
	standby_link_if.host lnk
);
	standby_pkg::host_state_t hstate_r;
	standby_pkg::host_op_t op_r;
	logic [1:0] step_r;
	logic [15:0] addr_r, wdata_r, rdata_r;
	logic err_r, stby_seen_r;
	logic [3:0] pin_val_r, pin_drv_r;
	// Separate low-active copy so the pad enable leaves a flop directly
	logic [3:0] pin_oe_n_r;
	logic req_r, we_r;
	logic [15:0] laddr_r, lwdata_r;

	wire busy = (hstate_r != standby_pkg::H_IDLE);
	wire hit_ctrl = (avs_address_i == `HOFF_CTRL);
	// Orders stall while a sequence runs, so none is lost
	wire accept = (avs_read_i | avs_write_i) & avs_waitrequest_o & ~(avs_write_i & hit_ctrl & busy);
	wire do_wr = avs_write_i & ~avs_waitrequest_o;
	wire [2:0] op_in = avs_writedata_i[2:0];
	wire start = do_wr & hit_ctrl & (op_in != 3'b000) & (op_in <= 3'b100);
	// The id memory answers only while the device runs
	wire refuse = start & (op_in == standby_pkg::OP_READ) & (addr_r == `OFF_ID_MEM) & stby_seen_r;

	wire [15:0] en_word = 16'(16'h0001 << `BIT_STBY_EN);
	wire [15:0] req_word = en_word | 16'(16'h0001 << `BIT_STBY_REQ);

	logic s_we, s_poll, s_want, s_last;
	logic [15:0] s_addr, s_wdata;
	always_comb begin
		s_we = 1'b1;
		s_poll = 1'b0;
		s_want = 1'b0;
		s_last = 1'b1;
		s_addr = `OFF_SYS_CTRL;
		s_wdata = en_word;
		unique case (op_r)
			standby_pkg::OP_WRITE: begin
				s_addr = addr_r;
				s_wdata = wdata_r;
			end
			standby_pkg::OP_READ: begin
				s_we = 1'b0;
				s_addr = addr_r;
			end
			standby_pkg::OP_ENTER: begin
				s_last = (step_r == 2'd2);
				s_wdata = (step_r == 2'd1) ? req_word : en_word;
				s_we = (step_r != 2'd2);
				s_poll = (step_r == 2'd2);
				s_want = 1'b1;
			end
			standby_pkg::OP_EXIT: begin
				s_last = (step_r == 2'd1);
				s_wdata = en_word;
				s_we = (step_r == 2'd0);
				s_poll = (step_r == 2'd1);
			end
			default: begin
				s_we = 1'b0;
			end
		endcase
	end

	wire got_stat = lnk.rdata[`BIT_STBY_STAT];
	wire retry = s_poll & (got_stat != s_want);

	wire [31:0] rd_mux = (avs_address_i == `HOFF_ADDR) ? {16'h0000, addr_r} :
		(avs_address_i == `HOFF_WDATA) ? {16'h0000, wdata_r} :
		(avs_address_i == `HOFF_CTRL) ? {30'h00000000, err_r, busy} :
		(avs_address_i == `HOFF_RDATA) ? {16'h0000, rdata_r} :
		(avs_address_i == `HOFF_PINS) ? {24'h000000, pin_drv_r, pin_val_r} :
		(avs_address_i == `HOFF_STAT) ? {31'h00000000, stby_seen_r} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
			addr_r <= 16'h0000;
			wdata_r <= 16'h0000;
			pin_val_r <= 4'h0;
			pin_drv_r <= 4'h0;
			pin_oe_n_r <= 4'hf;
			err_r <= 1'b0;
		end else begin
			avs_waitrequest_o <= ~accept;
			if (accept) begin
				avs_readdata_o <= rd_mux;
			end
			if (do_wr && avs_address_i == `HOFF_ADDR) begin
				addr_r <= avs_writedata_i[15:0];
			end
			if (do_wr && avs_address_i == `HOFF_WDATA) begin
				wdata_r <= avs_writedata_i[15:0];
			end
			if (do_wr && avs_address_i == `HOFF_PINS) begin
				pin_val_r <= avs_writedata_i[3:0];
				pin_drv_r <= avs_writedata_i[7:4];
				pin_oe_n_r <= ~avs_writedata_i[7:4];
			end
			// Set wins over a clear in the same write
			if (refuse) begin
				err_r <= 1'b1;
			end else if (do_wr && hit_ctrl && avs_writedata_i[`HCTRL_ERR_CLR]) begin
				err_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hstate_r <= standby_pkg::H_IDLE;
			op_r <= standby_pkg::OP_NONE;
			step_r <= 2'd0;
			rdata_r <= 16'h0000;
			stby_seen_r <= 1'b0;
			req_r <= 1'b0;
			we_r <= 1'b0;
			laddr_r <= 16'h0000;
			lwdata_r <= 16'h0000;
		end else begin
			req_r <= 1'b0;
			unique case (hstate_r)
				standby_pkg::H_IDLE: begin
					if (start && !refuse) begin
						op_r <= standby_pkg::host_op_t'(op_in);
						step_r <= 2'd0;
						hstate_r <= standby_pkg::H_ISSUE;
					end
				end
				standby_pkg::H_ISSUE: begin
					req_r <= 1'b1;
					we_r <= s_we;
					laddr_r <= s_addr;
					lwdata_r <= s_wdata;
					hstate_r <= standby_pkg::H_WAIT;
				end
				standby_pkg::H_WAIT: begin
					if (lnk.ack) begin
						if (!s_we) begin
							rdata_r <= lnk.rdata;
						end
						if (s_poll || (!s_we && s_addr == `OFF_SYS_CTRL)) begin
							stby_seen_r <= got_stat;
						end
						if (retry) begin
							hstate_r <= standby_pkg::H_ISSUE;
						end else if (s_last) begin
							hstate_r <= standby_pkg::H_IDLE;
						end else begin
							step_r <= step_r + 2'd1;
							hstate_r <= standby_pkg::H_ISSUE;
						end
					end
				end
				default: begin
					hstate_r <= standby_pkg::H_IDLE;
				end
			endcase
		end
	end

	assign lnk.req = req_r;
	assign lnk.we = we_r;
	assign lnk.addr = laddr_r;
	assign lnk.wdata = lwdata_r;
	assign lnk.host_gpio_o = pin_val_r;
	assign lnk.host_gpio_oe_n = pin_oe_n_r;
endmodule : standby_pad_host
`default_nettype wire

// *** testbench/standby_pad_asserts.sv ***
// Checker for the standby pad link between host and device ends.
// Assumes one clock and a synchronous active-high reset.
`include "standby_cfg.svh"
`default_nettype none
module standby_pad_asserts #(
	parameter logic [7:0] ID_BYTE0 = 8'h3c, // Arbitrary value
	parameter logic [7:0] ID_BYTE1 = 8'hc3 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic ack,
	input wire logic [15:0] rdata,
	// Pads and status
	input wire logic [3:0] dev_gpio_oe_n,
	input wire logic [7:0] pix_data,
	input wire logic pix_clk,
	input wire logic line_valid,
	input wire logic frame_valid,
	input wire logic pix_oe_n,
	input wire logic [3:0] diff,
	input wire logic standby_o,
	input wire logic [3:0] powerup_id_o
);
	logic rd_req;
	assign rd_req = req && !we;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	reset_pads_a: assert property ($fell(sys_rst_i) |-> pix_oe_n && dev_gpio_oe_n == 4'hf && diff == 4'h0 && !ack)
		else $error("pads not safe after reset");
	ack_once_a: assert property (req |=> ack ##1 !ack)
		else $error("request not answered by one ack");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	id_read_a: assert property (rd_req && addr == `OFF_ID_MEM |=> rdata == {ID_BYTE1, ID_BYTE0})
		else $error("id bytes wrong");
	status_read_a: assert property (rd_req && addr == `OFF_SYS_CTRL |=> rdata[14] == standby_o)
		else $error("status bit not the real state");
	powerup_read_a: assert property (rd_req && addr == `OFF_POWERUP_GPIO |=> rdata[3:0] == powerup_id_o)
		else $error("power-up levels misread");
	stby_diff_a: assert property (standby_o && $past(standby_o) |-> diff == 4'h0)
		else $error("differential lines not low in standby");
	stby_pixels_a: assert property (standby_o [*2] |-> pix_data == 8'h00 && !pix_clk && !line_valid && !frame_valid)
		else $error("pixel lines active in standby");
endmodule : standby_pad_asserts
`default_nettype wire

// *** testbench/standby_pad_control_tb.sv ***
// Bench for the host and device ends joined by the standby link.
// Assumes common/ and hdl/ are compiled first.
`include "standby_cfg.svh"
`default_nettype none
module standby_pad_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] a; logic w; logic [15:0] d; logic [15:0] e;} row_t;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [4:0] av_addr = 5'h00;
	logic av_rd_s = 1'b0;
	logic av_wr_s = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [9:0] pix_data_i = 10'h000;
	logic [2:0] pix_ctl = 3'h0;
	logic frame_end_i = 1'b0;
	logic flash_i = 1'b0;
	logic shutter_i = 1'b0;
	logic standby_o;
	logic [3:0] powerup_id_o;
	logic [15:0] rd;
	int err_count = 0;
	int cmp_count = 0;
	int n;
	// Ordinary register cases: address, write, data, expected read
	row_t rows [11] = '{'{16'h0030, 1'b1, 16'h0001, 16'h0001}, '{16'h1078, 1'b1, 16'h1e00, 16'h1e00},
		'{16'h0024, 1'b1, 16'h0005, 16'h000f}, '{16'h0040, 1'b0, 16'h0000, 16'hc33c},
		'{16'h0100, 1'b1, 16'h1234, 16'h0000}, '{16'h1078, 1'b1, 16'h0000, 16'h0000},
		'{16'h1076, 1'b1, 16'h1e00, 16'h0000}, '{16'h1074, 1'b1, 16'h0a00, 16'h0a00},
		'{16'h1070, 1'b1, 16'h0000, 16'h0a00}, '{16'h0018, 1'b1, 16'h4000, 16'h0000},
		'{16'h1078, 1'b1, 16'h1e00, 16'h1e00}};
	// Clock never stops, so it runs around every standby entry and exit
	always #5 clk_i = ~clk_i;
	standby_link_if link ();
	standby_pad_device u_standby_pad_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(link),
		.pix_data_i(pix_data_i), .pix_clk_i(pix_ctl[0]), .line_valid_i(pix_ctl[1]), .frame_valid_i(pix_ctl[2]),
		.frame_end_i(frame_end_i), .flash_i(flash_i), .shutter_i(shutter_i), .standby_o(standby_o),
		.powerup_id_o(powerup_id_o));
	standby_pad_host u_standby_pad_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(av_addr),
		.avs_read_i(av_rd_s), .avs_write_i(av_wr_s), .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
		.avs_waitrequest_o(av_wait), .lnk(link));
	standby_pad_asserts u_standby_pad_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req(link.req),
		.we(link.we), .addr(link.addr), .ack(link.ack), .rdata(link.rdata), .dev_gpio_oe_n(link.dev_gpio_oe_n),
		.pix_data(link.pix_data), .pix_clk(link.pix_clk), .line_valid(link.line_valid),
		.frame_valid(link.frame_valid), .pix_oe_n(link.pix_oe_n), .diff(link.diff), .standby_o(standby_o),
		.powerup_id_o(powerup_id_o));
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task hang;
		err_count++;
		$display("Error at %0t: wait ran out", $time);
		give_verdict();
	endtask : hang
	// Held until waitrequest is seen low; one idle edge keeps strobes from re-rising in one step
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		av_addr <= a;
		av_wdata <= d;
		av_wr_s <= w;
		av_rd_s <= !w;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (av_wait !== 1'b0 && k < 100);
		if (k >= 100)
			hang();
		rd = av_rdata[15:0];
		av_wr_s <= 1'b0;
		av_rd_s <= 1'b0;
		@(posedge clk_i);
	endtask : av
	task idle;
		int k;
		k = 0;
		do begin
			av(1'b0, `HOFF_CTRL, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 500);
		if (k >= 500)
			hang();
	endtask : idle
	task dev_wr(input logic [15:0] a, input logic [15:0] d);
		av(1'b1, `HOFF_ADDR, {16'h0, a});
		av(1'b1, `HOFF_WDATA, {16'h0, d});
		av(1'b1, `HOFF_CTRL, 32'h1);
		idle();
	endtask : dev_wr
	task dev_rd(input logic [15:0] a);
		av(1'b1, `HOFF_ADDR, {16'h0, a});
		av(1'b1, `HOFF_CTRL, 32'h2);
		idle();
		av(1'b0, `HOFF_RDATA, 32'h0);
	endtask : dev_rd
	initial begin
		repeat (19) @(posedge clk_i);
		chk({4'h0, av_wait, standby_o, link.pix_oe_n, link.ack, link.dev_gpio_oe_n, link.diff}, 16'h0af0);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		foreach (rows[i]) begin
			if (rows[i].w)
				dev_wr(rows[i].a, rows[i].d);
			dev_rd(rows[i].a);
			chk(rd, rows[i].e);
		end
		chk({12'h0, powerup_id_o}, 16'h000f);
		av(1'b0, 5'h18, 32'h0);
		chk(rd, 16'h0000);
		av(1'b1, `HOFF_PINS, 32'h000000fa);
		dev_rd(`OFF_GPIO_DATA);
		chk(rd, 16'h1400);
		// Pin-driven enable goes through a synchroniser, so allow it settling time
		dev_wr(`OFF_RESET_CTRL, 16'h0100);
		av(1'b1, `HOFF_PINS, 32'h000000f8);
		repeat (8) @(posedge clk_i);
		chk({15'h0, link.pix_oe_n}, 16'h0001);
		av(1'b1, `HOFF_PINS, 32'h000000f0);
		repeat (8) @(posedge clk_i);
		chk({15'h0, link.pix_oe_n}, 16'h0000);
		dev_wr(`OFF_RESET_CTRL, 16'h0000);
		av(1'b1, `HOFF_PINS, 32'h00000000);
		dev_wr(`OFF_PAD_CTRL, 16'h0003);
		chk({15'h0, link.pix_oe_n}, 16'h0001);
		pix_data_i <= 10'h2a5;
		pix_ctl <= 3'h7;
		dev_wr(`OFF_PAD_CTRL, 16'h0009);
		chk({14'h0, link.gpio_lvl[1:0]}, 16'h0001);
		chk({4'h0, link.pix_oe_n, link.pix_data, link.pix_clk, link.line_valid, link.frame_valid}, 16'h054f);
		flash_i <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			dev_wr(`OFF_PAD_CTRL, i == 0 ? 16'h0011 : 16'h0031);
			chk({15'h0, link.gpio_lvl[2]}, {15'h0, i == 0});
		end
		dev_wr(`OFF_PAD_CTRL, 16'h0001);
		// Enter: standby must wait for the frame end plus the tail count
		av(1'b1, `HOFF_CTRL, 32'h3);
		repeat (20) @(posedge clk_i);
		chk({15'h0, standby_o}, 16'h0000);
		frame_end_i <= 1'b1;
		@(posedge clk_i);
		frame_end_i <= 1'b0;
		n = 0;
		while (standby_o !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 300)
			hang();
		chk({15'h0, n >= `ENTRY_TAIL_CYC && n <= `ENTRY_TAIL_CYC + 3}, 16'h0001);
		idle();
		av(1'b0, `HOFF_STAT, 32'h0);
		chk({15'h0, rd[0]}, 16'h0001);
		dev_rd(`OFF_SYS_CTRL);
		chk(rd, 16'h4009);
		chk({11'h0, link.pix_oe_n, link.diff}, 16'h0010);
		dev_wr(`OFF_PAD_CTRL, 16'h0005);
		chk({15'h0, link.pix_oe_n}, 16'h0000);
		dev_wr(`OFF_PAD_CTRL, 16'h0001);
		av(1'b1, `HOFF_ADDR, {16'h0, `OFF_ID_MEM});
		av(1'b1, `HOFF_CTRL, 32'h2);
		idle();
		chk({15'h0, rd[1]}, 16'h0001);
		av(1'b1, `HOFF_CTRL, 32'h100);
		av(1'b0, `HOFF_CTRL, 32'h0);
		chk({14'h0, rd[1:0]}, 16'h0000);
		av(1'b1, `HOFF_CTRL, 32'h4);
		idle();
		av(1'b0, `HOFF_STAT, 32'h0);
		chk({14'h0, standby_o, rd[0]}, 16'h0000);
		give_verdict();
	end
endmodule : standby_pad_control_tb
`default_nettype wire
